// ### core/asp_top.sv
`default_nettype none
`include "asp_map.svh"
module asp_top (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic RXD_PIN,
	input wire logic IR_RX_PIN,
	output logic TXD_PIN,
	output logic IR_TX_PIN,
	output logic IRQ,
	output logic TX_DMA_REQ,
	output logic RX_DMA_REQ
);
	logic ack_r; // Bus answer cycle
	logic wr_go; // Write taken this edge
	logic rd_go; // Read taken this edge
	logic [31:0] be_mask; // Byte lanes as a bit mask
	logic [31:0] rd_val; // Current value at the addressed register
	logic [31:0] wval; // Addressed register after a masked write
	logic [31:0] rdata_r; // Read data held for the bus
	logic [7:0] ctrl_r; // Mode and enable bits
	logic [15:0] div_r; // Baud divisor
	logic [5:0] txthr_r; // Transmit threshold
	logic [5:0] rxthr_r; // Receive threshold
	logic [7:0] mask_r; // Interrupt mask
	logic [7:0] stat_r; // Sticky event bits
	logic [7:0] ev; // Events this cycle
	logic [15:0] bdiv_r; // Baud prescaler
	logic tick_r; // Sixteen-times-bit-rate tick
	logic [1:0] s1_r; // Pin synchroniser, first stage
	logic [1:0] s2_r; // Pin synchroniser, second stage
	logic [1:0] pin_in;
	logic line; // Selected receive line
	logic txq_push;
	logic txq_pop;
	logic [7:0] txq_head;
	logic txq_full;
	logic txq_empty;
	logic [5:0] txq_lvl;
	logic rxq_pop;
	logic [10:0] rxq_head;
	logic rxq_full;
	logic rxq_empty;
	logic [5:0] rxq_lvl;
	logic rx_done;
	logic [7:0] rx_data;
	logic rx_perr;
	logic rx_ferr;
	logic rx_brk;
	logic rx_idle;
	logic rx_busy;
	asp_pkg::asp_bit_state_t tx_st_r; // Transmit phase
	logic [3:0] tx_tk_r; // Tick within transmit bit
	logic [2:0] tx_idx_r; // Transmit data index
	logic [7:0] tx_sh_r; // Transmit shift register
	logic tx_stop2_r; // Second stop bit in progress
	logic tx_last;
	logic tx_lvl; // NRZ level of the current bit
	logic ab_en;
	logic ab_meas_r; // Measuring a low pulse
	logic [19:0] ab_cnt_r; // Clocks in the low pulse
	logic ab_done_r; // Measurement finished
	logic [15:0] ab_div; // Divisor from the measurement

	// Avalon-MM handshake: every access waits exactly one cycle
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
	assign wr_go = AVS_WRITE & ack_r;
	assign rd_go = AVS_READ & ack_r;
	assign AVS_READDATA = rdata_r;
	assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
		{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
	assign wval = (rd_val & ~be_mask) | (AVS_WRITEDATA & be_mask);

	// Answer flag drops after one cycle so back-to-back requests each wait
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (AVS_READ | AVS_WRITE) & ~ack_r;
		end
	end

	// Read mux; unmapped offsets read as zero
	always_comb begin
		rd_val = 32'h0000_0000;
		if (AVS_ADDRESS == `ASP_OFS_DATA) begin
			// An empty queue reads as zero rather than a stale entry
			rd_val = {16'h0000, ~rxq_empty, 4'h0, rxq_empty ? 11'h000 : rxq_head};
		end else if (AVS_ADDRESS == `ASP_OFS_CTRL) begin
			rd_val = {24'h00_0000, ctrl_r};
		end else if (AVS_ADDRESS == `ASP_OFS_DIV) begin
			rd_val = {16'h0000, div_r};
		end else if (AVS_ADDRESS == `ASP_OFS_THR) begin
			rd_val = {10'h000, rxthr_r, 10'h000, txthr_r};
		end else if (AVS_ADDRESS == `ASP_OFS_STAT) begin
			rd_val = {24'h00_0000, stat_r};
		end else if (AVS_ADDRESS == `ASP_OFS_MASK) begin
			rd_val = {24'h00_0000, mask_r};
		end else if (AVS_ADDRESS == `ASP_OFS_LVL) begin
			rd_val = {14'h0000, ab_meas_r, rx_busy, 2'h0, rxq_lvl, 2'h0, txq_lvl};
		end
	end

	// Read data is captured in the wait cycle and held for the master
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_r <= 32'h0000_0000;
		end else if (AVS_READ & ~ack_r) begin
			rdata_r <= rd_val;
		end
	end

	// Control register; a bus write wins over the autobaud self-clear
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_r <= `ASP_CTRL_RST;
		end else if (wr_go & (AVS_ADDRESS == `ASP_OFS_CTRL)) begin
			ctrl_r <= wval[7:0];
		end else if (ab_done_r) begin
			ctrl_r[`ASP_CTL_ABEN] <= 1'b0;
		end
	end

	// Divisor, written by software or loaded by the autobaud measurement
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			div_r <= `ASP_DIV_RST;
		end else if (wr_go & (AVS_ADDRESS == `ASP_OFS_DIV)) begin
			div_r <= wval[15:0];
		end else if (ab_done_r) begin
			div_r <= ab_div;
		end
	end

	// Thresholds and interrupt mask
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			txthr_r <= `ASP_TXTHR_RST;
			rxthr_r <= `ASP_RXTHR_RST;
			mask_r <= `ASP_MASK_RST;
		end else if (wr_go) begin
			if (AVS_ADDRESS == `ASP_OFS_THR) begin
				txthr_r <= wval[5:0];
				rxthr_r <= wval[21:16];
			end else if (AVS_ADDRESS == `ASP_OFS_MASK) begin
				mask_r <= wval[7:0];
			end
		end
	end

	// Events; threshold events are levels and re-set while the level holds
	always_comb begin
		ev = 8'h00;
		ev[`ASP_ST_TXTHR] = (txq_lvl <= txthr_r);
		ev[`ASP_ST_RXTHR] = (rxq_lvl >= rxthr_r);
		ev[`ASP_ST_FRAME] = rx_done & rx_ferr;
		ev[`ASP_ST_PARITY] = rx_done & rx_perr;
		ev[`ASP_ST_BREAK] = rx_done & rx_brk;
		ev[`ASP_ST_IDLE] = rx_idle;
		ev[`ASP_ST_OVERRUN] = rx_done & rxq_full;
		ev[`ASP_ST_ABDONE] = ab_done_r;
	end

	// Sticky status; a read clears only the bits it returned, new events win
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			stat_r <= 8'h00;
		end else if (rd_go & (AVS_ADDRESS == `ASP_OFS_STAT)) begin
			stat_r <= (stat_r & ~rdata_r[7:0]) | ev;
		end else begin
			stat_r <= stat_r | ev;
		end
	end

	// Interrupt and DMA requests
	assign IRQ = |(stat_r & mask_r);
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			TX_DMA_REQ <= 1'b0;
			RX_DMA_REQ <= 1'b0;
		end else begin
			TX_DMA_REQ <= ev[`ASP_ST_TXTHR];
			RX_DMA_REQ <= ev[`ASP_ST_RXTHR];
		end
	end

	// Baud prescaler: one tick every div+1 clocks, sixteen ticks per bit
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			bdiv_r <= 16'h0000;
			tick_r <= 1'b0;
		end else if (bdiv_r >= div_r) begin
			bdiv_r <= 16'h0000;
			tick_r <= 1'b1;
		end else begin
			bdiv_r <= bdiv_r + 16'h0001;
			tick_r <= 1'b0;
		end
	end

	// Two-stage synchronisers for both receive pins; both idle high
	assign pin_in = {IR_RX_PIN, RXD_PIN};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge CLK or negedge RST_N) begin
				if (!RST_N) begin
					s1_r[gi] <= 1'b1;
					s2_r[gi] <= 1'b1;
				end else begin
					s1_r[gi] <= pin_in[gi];
					s2_r[gi] <= s1_r[gi];
				end
			end
		end
	endgenerate
	assign line = ctrl_r[`ASP_CTL_IRDA] ? s2_r[1] : s2_r[0];

	// Transmit queue; a write to a full queue is dropped
	assign txq_push = wr_go & (AVS_ADDRESS == `ASP_OFS_DATA) & AVS_BYTEENABLE[0];
	assign txq_pop = (tx_st_r == asp_pkg::ASP_IDLE) & ctrl_r[`ASP_CTL_TXEN] & ~txq_empty;
	asp_queue #(.W(8)) u_txq (
		.clk(CLK),
		.rst_n(RST_N),
		.push(txq_push),
		.wdata(AVS_WRITEDATA[7:0]),
		.pop(txq_pop),
		.head(txq_head),
		.full(txq_full),
		.empty(txq_empty),
		.level(txq_lvl)
	);

	// Receive queue holds character plus its error flags
	assign rxq_pop = rd_go & (AVS_ADDRESS == `ASP_OFS_DATA);
	asp_queue #(.W(11)) u_rxq (
		.clk(CLK),
		.rst_n(RST_N),
		.push(rx_done),
		.wdata({rx_brk, rx_ferr, rx_perr, rx_data}),
		.pop(rxq_pop),
		.head(rxq_head),
		.full(rxq_full),
		.empty(rxq_empty),
		.level(rxq_lvl)
	);

	// Receiver is held off while autobaud owns the line
	asp_rx u_rx (
		.clk(CLK),
		.rst_n(RST_N),
		.en(ctrl_r[`ASP_CTL_RXEN] & ~ab_en),
		.line(line),
		.irda(ctrl_r[`ASP_CTL_IRDA]),
		.tick(tick_r),
		.eight(ctrl_r[`ASP_CTL_EIGHT]),
		.par_en(ctrl_r[`ASP_CTL_PAREN]),
		.par_odd(ctrl_r[`ASP_CTL_PARODD]),
		.done(rx_done),
		.data(rx_data),
		.perr(rx_perr),
		.ferr(rx_ferr),
		.brk(rx_brk),
		.idle(rx_idle),
		.busy(rx_busy)
	);

	// Transmit tick counter
	assign tx_last = tick_r & (tx_tk_r == `ASP_TICKS_LAST);
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_tk_r <= 4'h0;
		end else if (tx_st_r == asp_pkg::ASP_IDLE) begin
			tx_tk_r <= 4'h0;
		end else if (tick_r) begin
			tx_tk_r <= tx_tk_r + 4'h1;
		end
	end

	// Transmit state machine
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_st_r <= asp_pkg::ASP_IDLE;
			tx_idx_r <= 3'h0;
			tx_sh_r <= 8'h00;
			tx_stop2_r <= 1'b0;
		end else begin
			case (tx_st_r)
				asp_pkg::ASP_IDLE: begin
					tx_idx_r <= 3'h0;
					tx_stop2_r <= 1'b0;
					if (txq_pop) begin
						// Seven-bit mode drops bit 7 so parity covers only sent bits
						tx_sh_r <= ctrl_r[`ASP_CTL_EIGHT] ? txq_head
							: {1'b0, txq_head[6:0]};
						tx_st_r <= asp_pkg::ASP_START;
					end
				end
				asp_pkg::ASP_START: begin
					if (tx_last) begin
						tx_st_r <= asp_pkg::ASP_DATA;
					end
				end
				asp_pkg::ASP_DATA: begin
					if (tx_last) begin
						if (tx_idx_r == (ctrl_r[`ASP_CTL_EIGHT] ? 3'h7 : 3'h6)) begin
							tx_st_r <= ctrl_r[`ASP_CTL_PAREN] ? asp_pkg::ASP_PARITY
								: asp_pkg::ASP_STOP;
						end else begin
							tx_idx_r <= tx_idx_r + 3'h1;
						end
					end
				end
				asp_pkg::ASP_PARITY: begin
					if (tx_last) begin
						tx_st_r <= asp_pkg::ASP_STOP;
					end
				end
				default: begin
					if (tx_last) begin
						if (ctrl_r[`ASP_CTL_TWOSTOP] & ~tx_stop2_r) begin
							tx_stop2_r <= 1'b1;
						end else begin
							tx_st_r <= asp_pkg::ASP_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Line level per phase: start low, data LSB first, parity, stops high
	always_comb begin
		case (tx_st_r)
			asp_pkg::ASP_START: tx_lvl = 1'b0;
			asp_pkg::ASP_DATA: tx_lvl = tx_sh_r[tx_idx_r];
			asp_pkg::ASP_PARITY: tx_lvl = ^tx_sh_r ^ ctrl_r[`ASP_CTL_PARODD];
			default: tx_lvl = 1'b1;
		endcase
	end

	// Output pins; infrared sends a short high pulse for each zero bit
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			TXD_PIN <= 1'b1;
			IR_TX_PIN <= 1'b0;
		end else begin
			TXD_PIN <= ctrl_r[`ASP_CTL_IRDA] | tx_lvl;
			IR_TX_PIN <= ctrl_r[`ASP_CTL_IRDA] & ~tx_lvl & (tx_tk_r < `ASP_IR_PULSE);
		end
	end

	// Autobaud: times the first low pulse, which must be exactly one bit
	// long, so the far end should send a character whose bit 0 is one
	assign ab_en = ctrl_r[`ASP_CTL_ABEN];
	assign ab_div = (ab_cnt_r[19:4] == 16'h0000) ? 16'h0000 : ab_cnt_r[19:4] - 16'h0001;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ab_meas_r <= 1'b0;
			ab_cnt_r <= 20'h0_0000;
			ab_done_r <= 1'b0;
		end else begin
			ab_done_r <= 1'b0;
			if (~ab_en | ab_done_r) begin
				ab_meas_r <= 1'b0;
			end else if (~ab_meas_r) begin
				if (~line) begin
					ab_meas_r <= 1'b1;
					ab_cnt_r <= 20'h0_0001;
				end
			end else if (line) begin
				ab_meas_r <= 1'b0;
				ab_done_r <= 1'b1;
			end else if (ab_cnt_r != 20'hf_ffff) begin
				ab_cnt_r <= ab_cnt_r + 20'h0_0001;
			end
		end
	end
endmodule
`default_nettype wire

// ### shared/asp_map.svh
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
// Register byte offsets on the Avalon-MM slave
`define ASP_OFS_DATA 5'h00
`define ASP_OFS_CTRL 5'h04
`define ASP_OFS_DIV 5'h08
`define ASP_OFS_THR 5'h0c
`define ASP_OFS_STAT 5'h10
`define ASP_OFS_MASK 5'h14
`define ASP_OFS_LVL 5'h18
// Control register bit positions
`define ASP_CTL_TXEN 0
`define ASP_CTL_RXEN 1
`define ASP_CTL_EIGHT 2
`define ASP_CTL_TWOSTOP 3
`define ASP_CTL_PAREN 4
`define ASP_CTL_PARODD 5
`define ASP_CTL_IRDA 6
`define ASP_CTL_ABEN 7
// Status and mask bit positions
`define ASP_ST_TXTHR 0
`define ASP_ST_RXTHR 1
`define ASP_ST_FRAME 2
`define ASP_ST_PARITY 3
`define ASP_ST_BREAK 4
`define ASP_ST_IDLE 5
`define ASP_ST_OVERRUN 6
`define ASP_ST_ABDONE 7
// Receive entry flag positions
`define ASP_RXE_PERR 8
`define ASP_RXE_FERR 9
`define ASP_RXE_BRK 10
// Reset values
`define ASP_CTRL_RST 8'h07
`define ASP_DIV_RST 16'h0015
`define ASP_TXTHR_RST 6'h02
`define ASP_RXTHR_RST 6'h01
`define ASP_MASK_RST 8'h00
// Timing counts in oversampling ticks, sixteen per bit
`define ASP_TICKS_LAST 4'hf
`define ASP_MID_TICK 4'h7
`define ASP_IR_PULSE 4'h3
`define ASP_IDLE_TICKS 8'ha0
// Queue geometry
`define ASP_QFULL 6'h20
`endif

// ### shared/asp_pkg.sv
`default_nettype none
package asp_pkg;
	// Phase of one serial character, shared by transmitter and receiver
	typedef enum logic [2:0] {
		ASP_IDLE,
		ASP_START,
		ASP_DATA,
		ASP_PARITY,
		ASP_STOP
	} asp_bit_state_t;
endpackage
`default_nettype wire

// ### core/asp_queue.sv
`default_nettype none
`include "asp_map.svh"
// Thirty-two entry first-in first-out queue; push to a full or pop of an
// empty queue is ignored, so callers must look at full and empty
module asp_queue #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic [W-1:0] wdata,
	input wire logic pop,
	output logic [W-1:0] head,
	output logic full,
	output logic empty,
	output logic [5:0] level
);
	logic [W-1:0] mem [0:31]; // Storage array
	logic [4:0] wp_r; // Write pointer, wraps at 32
	logic [4:0] rp_r; // Read pointer, wraps at 32
	logic [5:0] cnt_r; // Fill level 0..32
	logic do_push;
	logic do_pop;

	assign full = (cnt_r == `ASP_QFULL);
	assign empty = (cnt_r == 6'h00);
	assign level = cnt_r;
	assign head = mem[rp_r];
	assign do_push = push & ~full;
	assign do_pop = pop & ~empty;

	// Data array, no reset so it maps onto plain storage
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wp_r] <= wdata;
		end
	end

	// Pointers and level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= 5'h00;
			rp_r <= 5'h00;
			cnt_r <= 6'h00;
		end else begin
			if (do_push) begin
				wp_r <= wp_r + 5'h01;
			end
			if (do_pop) begin
				rp_r <= rp_r + 5'h01;
			end
			if (do_push & ~do_pop) begin
				cnt_r <= cnt_r + 6'h01;
			end else if (do_pop & ~do_push) begin
				cnt_r <= cnt_r - 6'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### core/asp_rx.sv
`default_nettype none
`include "asp_map.svh"
// Serial receiver; line is already synchronised and idles high
module asp_rx (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic line,
	input wire logic irda,
	input wire logic tick,
	input wire logic eight,
	input wire logic par_en,
	input wire logic par_odd,
	output logic done,
	output logic [7:0] data,
	output logic perr,
	output logic ferr,
	output logic brk,
	output logic idle,
	output logic busy
);
	asp_pkg::asp_bit_state_t st_r; // Character phase
	logic [3:0] tk_r; // Tick within the bit
	logic [2:0] idx_r; // Data bit index
	logic samp_r; // Value gathered for the current bit
	logic [7:0] sh_r; // Assembled data
	logic par_r; // Received parity bit
	logic [7:0] idle_r; // Ticks of high line after a character
	logic armed_r; // One idle report per gap
	logic last;
	logic [2:0] top;

	assign last = tick & (tk_r == `ASP_TICKS_LAST);
	assign top = eight ? 3'h7 : 3'h6;
	assign busy = (st_r != asp_pkg::ASP_IDLE);

	// Tick counter, restarted at the start edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tk_r <= 4'h0;
		end else if (st_r == asp_pkg::ASP_IDLE) begin
			tk_r <= 4'h0;
		end else if (tick) begin
			tk_r <= tk_r + 4'h1;
		end
	end

	// Bit sampling: mid-bit for NRZ, any low pulse in the bit for infrared
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			samp_r <= 1'b1;
		end else if (st_r == asp_pkg::ASP_IDLE) begin
			samp_r <= 1'b1;
		end else if (tick) begin
			if (tk_r == 4'h0) begin
				samp_r <= line;
			end else if (irda) begin
				samp_r <= samp_r & line;
			end else if (tk_r == `ASP_MID_TICK) begin
				samp_r <= line;
			end
		end
	end

	// Character state machine and result flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= asp_pkg::ASP_IDLE;
			idx_r <= 3'h0;
			sh_r <= 8'h00;
			par_r <= 1'b0;
			done <= 1'b0;
			data <= 8'h00;
			perr <= 1'b0;
			ferr <= 1'b0;
			brk <= 1'b0;
		end else begin
			done <= 1'b0;
			case (st_r)
				asp_pkg::ASP_IDLE: begin
					idx_r <= 3'h0;
					sh_r <= 8'h00;
					if (en & ~line) begin
						st_r <= asp_pkg::ASP_START;
					end
				end
				asp_pkg::ASP_START: begin
					// A start that is high again is a glitch, not a character
					if (last) begin
						st_r <= samp_r ? asp_pkg::ASP_IDLE : asp_pkg::ASP_DATA;
					end
				end
				asp_pkg::ASP_DATA: begin
					if (last) begin
						sh_r[idx_r] <= samp_r;
						if (idx_r == top) begin
							st_r <= par_en ? asp_pkg::ASP_PARITY : asp_pkg::ASP_STOP;
						end else begin
							idx_r <= idx_r + 3'h1;
						end
					end
				end
				asp_pkg::ASP_PARITY: begin
					if (last) begin
						par_r <= samp_r;
						st_r <= asp_pkg::ASP_STOP;
					end
				end
				default: begin
					// Only the first stop bit is checked; a second one reads as idle
					if (last) begin
						st_r <= asp_pkg::ASP_IDLE;
						done <= 1'b1;
						data <= sh_r;
						ferr <= ~samp_r;
						perr <= par_en & (par_r != (^sh_r ^ par_odd));
						brk <= ~samp_r & (sh_r == 8'h00) & (~par_en | ~par_r);
					end
				end
			endcase
		end
	end

	// Idle line detection: ten bit times of high line after a character
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_r <= 8'h00;
			armed_r <= 1'b0;
			idle <= 1'b0;
		end else begin
			idle <= 1'b0;
			if (st_r != asp_pkg::ASP_IDLE) begin
				idle_r <= 8'h00;
				armed_r <= 1'b1;
			end else if (tick & armed_r) begin
				if (idle_r == `ASP_IDLE_TICKS) begin
					idle <= 1'b1;
					armed_r <= 1'b0;
				end else begin
					idle_r <= idle_r + 8'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### bench/asp_top_properties.sv
`default_nettype none
// Watches only the top ports: bus handshake, serial pins, reset levels
module asp_top_properties (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic RXD_PIN,
	input wire logic IR_RX_PIN,
	input wire logic TXD_PIN,
	input wire logic IR_TX_PIN,
	input wire logic IRQ,
	input wire logic TX_DMA_REQ,
	input wire logic RX_DMA_REQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// A fresh request always sees one wait cycle first
	a_wait_at_start: assert property ($rose(AVS_READ) || $rose(AVS_WRITE) |-> AVS_WAITREQUEST)
		else $error("no wait on new request");
	// Exactly one wait: the cycle after a waited request is answered
	a_wait_only_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
		|=> !AVS_WAITREQUEST || !(AVS_READ || AVS_WRITE))
		else $error("request waited twice");
	// Waitrequest never stands without a request
	a_idle_no_wait: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
		else $error("wait without request");
	// Read data only moves in a read's wait cycle
	a_rdata_holds: assert property (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
		else $error("read data moved");
	// A start bit is at least half a bit long, even at the fastest divisor
	a_start_bit_len: assert property ($fell(TXD_PIN) |-> !TXD_PIN [*8])
		else $error("start bit too short");
	// Infrared pulse spans at least three clocks
	a_ir_pulse_len: assert property ($rose(IR_TX_PIN) |-> IR_TX_PIN [*3])
		else $error("infrared pulse too short");
	// Only one of the two line encodings is driven at a time
	a_ir_txd_quiet: assert property (IR_TX_PIN |-> TXD_PIN)
		else $error("wire active in infrared mode");
	// Empty transmit queue is below the default threshold right after reset
	a_tx_dma_reset: assert property ($rose(RST_N) |=> TX_DMA_REQ)
		else $error("no transmit dma request after reset");
	// In reset the line idles and nothing is flagged
	a_reset_levels: assert property (disable iff (1'b0) !RST_N
		|-> TXD_PIN && !IR_TX_PIN && !IRQ && !RX_DMA_REQ)
		else $error("outputs active in reset");
endmodule
bind asp_top asp_top_properties u_props (.CLK(CLK), .RST_N(RST_N),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.RXD_PIN(RXD_PIN), .IR_RX_PIN(IR_RX_PIN), .TXD_PIN(TXD_PIN), .IR_TX_PIN(IR_TX_PIN),
	.IRQ(IRQ), .TX_DMA_REQ(TX_DMA_REQ), .RX_DMA_REQ(RX_DMA_REQ));
`default_nettype wire

// ### bench/asp_line_model.sv
`default_nettype none
// Far-end serial device: drives the receive pins, listens to the transmit pins
module asp_line_model (
	input wire logic clk,
	input wire logic txd,
	input wire logic ir_tx,
	output logic rxd,
	output logic ir_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	// Both lines idle high, as a pulled-up link does
	initial begin
		rxd = 1'b1;
		ir_rx = 1'b1;
	end
	// Frame bits go out in index order; caller builds start, data, parity, stops
	task automatic send(input logic [11:0] f, input int n, input int cpb, input logic ir);
		for (int i = 0; i < n; i++) begin
			for (int c = 0; c < cpb; c++) begin
				@(posedge clk);
				// Infrared zero is a short low pulse at the bit front
				if (ir)
					ir_rx <= f[i] || c >= 3;
				else
					rxd <= f[i];
			end
		end
		@(posedge clk);
		rxd <= 1'b1;
		ir_rx <= 1'b1;
		// The character lands in the receive queue a few clocks later: sync plus start-detect lag
		repeat (6) @(posedge clk);
	endtask
	// Waits for a start, then samples mid-bit, or the pulse slot in infrared
	task automatic grab(input int n, input int cpb, input logic ir,
		output logic [11:0] f, output logic ok);
		int k;
		k = 0;
		f = '1;
		while ((ir ? !ir_tx : txd) && k < 4000) begin
			@(posedge clk);
			k++;
		end
		ok = k < 4000;
		for (int i = 0; i < n; i++) begin
			for (int c = 0; c < cpb; c++) begin
				@(posedge clk);
				if (ir && c == 0 && ir_tx)
					f[i] = 1'b0;
				if (!ir && c == cpb / 2 - 1)
					f[i] = txd;
			end
		end
	endtask
endmodule
`default_nettype wire

// ### bench/test_asp_top.sv
`default_nettype none
`include "asp_map.svh"
module test_asp_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rd, wr, wait_req, txd, irtx, irq, txdma, rxdma, rxd, irrx, ok;
	logic rst_n = 1'b1; // Starts high so the time-zero drop is a real edge
	logic [4:0] adr;
	logic [31:0] wd, rdat, q;
	logic [11:0] f, g;
	logic [7:0] ch, d;
	int n;
	int mismatches = 0;
	int tests_run = 0;
	// Character formats: 8N1, 7N2, 8E1, 7O1
	logic [7:0] fmt [4] = '{8'h07, 8'h0b, 8'h17, 8'h33};
	asp_top DUT (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wait_req), .RXD_PIN(rxd), .IR_RX_PIN(irrx), .TXD_PIN(txd),
		.IR_TX_PIN(irtx), .IRQ(irq), .TX_DMA_REQ(txdma), .RX_DMA_REQ(rxdma));
	asp_line_model line (.clk(clk), .txd(txd), .ir_tx(irtx), .rxd(rxd), .ir_rx(irrx));
	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	// One bus access; request held until waitrequest is sampled low
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] dv);
		int k;
		k = 0;
		adr <= a;
		wd <= dv;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			k++;
		end while (wait_req !== 1'b0 && k < 16);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		if (k >= 16) begin
			mismatches++;
			complete_run();
		end
		// Lets the release land before another request
		@(posedge clk);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string nm);
		acc(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	function automatic logic [11:0] msk(input int k);
		return 12'((1 << k) - 1);
	endfunction
	// Expected frame, start bit at index 0
	function automatic logic [11:0] frame(input logic [7:0] c, input logic [7:0] ct,
		output int k);
		logic [11:0] fr;
		logic [7:0] dd;
		dd = ct[`ASP_CTL_EIGHT] ? c : {1'b0, c[6:0]};
		fr = '1;
		fr[0] = 1'b0;
		for (int i = 0; i < 8; i++)
			fr[i + 1] = dd[i];
		k = ct[`ASP_CTL_EIGHT] ? 9 : 8;
		if (ct[`ASP_CTL_PAREN]) begin
			fr[k] = ct[`ASP_CTL_PARODD] ? ~^dd : ^dd;
			k++;
		end
		fr[k] = 1'b1;
		fr[k + 1] = 1'b1;
		k = k + (ct[`ASP_CTL_TWOSTOP] ? 2 : 1);
		return fr;
	endfunction
	initial begin
		rst_n <= 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		adr = 5'h00;
		wd = 32'h0;
		cyc(5);
		rst_n <= 1'b1;
		cyc(1);
		rdc(`ASP_OFS_CTRL, 32'h07, "ctrl reset");
		rdc(`ASP_OFS_DIV, 32'h15, "div reset");
		rdc(`ASP_OFS_THR, 32'h00010002, "thr reset");
		rdc(5'h1c, 32'h0, "unmapped");
		acc(1'b1, `ASP_OFS_DIV, 32'h0);
		$display("test reset done");
		// Every format both ways
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, `ASP_OFS_CTRL, {24'h0, fmt[i]});
			ch = 8'hb5 ^ 8'(i * 51);
			d = fmt[i][2] ? ch : {1'b0, ch[6:0]};
			f = frame(ch, fmt[i], n);
			fork
				acc(1'b1, `ASP_OFS_DATA, {24'h0, ch});
				line.grab(n, 16, 1'b0, g, ok);
			join
			chk("tx start", 32'h1, {31'h0, ok});
			chk("tx frame", {20'h0, f & msk(n)}, {20'h0, g & msk(n)});
			line.send(f, n, 16, 1'b0);
			rdc(`ASP_OFS_DATA, {16'h0, 8'h80, d}, "rx char");
		end
		$display("test formats done");
		// Parity, framing, break and idle; framing unmasked
		acc(1'b1, `ASP_OFS_MASK, 32'h04);
		acc(1'b1, `ASP_OFS_CTRL, 32'h17);
		f = frame(8'h01, 8'h17, n);
		f[9] = ~f[9];
		line.send(f, n, 16, 1'b0);
		rdc(`ASP_OFS_DATA, 32'h8101, "parity flag");
		f = frame(8'h02, 8'h17, n);
		f[10] = 1'b0;
		line.send(f, n, 16, 1'b0);
		rdc(`ASP_OFS_DATA, 32'h8202, "framing flag");
		chk("irq set", 32'h1, {31'h0, irq});
		acc(1'b0, `ASP_OFS_STAT, 32'h0);
		chk("err status", 32'h0c, q & 32'h0c);
		cyc(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		line.send(12'h0, 11, 16, 1'b0);
		rdc(`ASP_OFS_DATA, 32'h8600, "break char");
		cyc(200);
		acc(1'b0, `ASP_OFS_STAT, 32'h0);
		chk("break idle", 32'h30, q & 32'h30);
		$display("test errors done");
		// Receive queue to full, one more overruns, then drain
		acc(1'b1, `ASP_OFS_CTRL, 32'h07);
		for (int i = 0; i < 33; i++) begin
			f = frame(8'h40 + 8'(i), 8'h07, n);
			line.send(f, n, 16, 1'b0);
		end
		acc(1'b0, `ASP_OFS_LVL, 32'h0);
		chk("rx level", 32'h20, (q >> 8) & 32'h3f);
		chk("rx dma", 32'h1, {31'h0, rxdma});
		acc(1'b0, `ASP_OFS_STAT, 32'h0);
		chk("overrun", 32'h40, q & 32'h40);
		for (int i = 0; i < 32; i++)
			rdc(`ASP_OFS_DATA, {16'h0, 8'h80, 8'h40 + 8'(i)}, "rx drain");
		rdc(`ASP_OFS_DATA, 32'h0, "rx empty");
		cyc(2);
		chk("rx dma off", 32'h0, {31'h0, rxdma});
		$display("test queue done");
		// Infrared both ways
		acc(1'b1, `ASP_OFS_CTRL, 32'h47);
		f = frame(8'h96, 8'h07, n);
		fork
			acc(1'b1, `ASP_OFS_DATA, 32'h96);
			line.grab(n, 16, 1'b1, g, ok);
		join
		chk("ir tx start", 32'h1, {31'h0, ok});
		chk("ir tx frame", {20'h0, f & msk(n)}, {20'h0, g & msk(n)});
		line.send(f, n, 16, 1'b1);
		rdc(`ASP_OFS_DATA, 32'h8096, "ir rx char");
		$display("test infrared done");
		// Rate detection from a 32-clock start bit; receiver off so the frame tail is not taken
		acc(1'b1, `ASP_OFS_CTRL, 32'h85);
		f = frame(8'h55, 8'h07, n);
		line.send(f, n, 32, 1'b0);
		cyc(4);
		rdc(`ASP_OFS_CTRL, 32'h05, "autobaud off");
		rdc(`ASP_OFS_DIV, 32'h1, "autobaud div");
		acc(1'b0, `ASP_OFS_STAT, 32'h0);
		chk("autobaud done", 32'h80, q & 32'h80);
		$display("test autobaud done");
		// Transmit queue overfilled, then drained
		acc(1'b1, `ASP_OFS_DIV, 32'h0);
		for (int i = 0; i < 34; i++)
			acc(1'b1, `ASP_OFS_DATA, i);
		rdc(`ASP_OFS_LVL, 32'h20, "tx level");
		chk("tx dma full", 32'h0, {31'h0, txdma});
		for (int k = 0; k < 400 && q[5:0] !== 6'h0; k++) begin
			cyc(20);
			acc(1'b0, `ASP_OFS_LVL, 32'h0);
		end
		chk("tx drained", 32'h0, q & 32'h3f);
		chk("tx dma empty", 32'h1, {31'h0, txdma});
		$display("test transmit queue done");
		complete_run();
	end
endmodule
`default_nettype wire
